// ==== sdram_command_refresh_scheduler.sv ====
// Contract
// - command, write-data and read-data fifos hold 7, 11 and 17 doublewords
// - memory and register accesses share one port with parallel command and data
// - each master normally offers its oldest pending command
// - read passes older writes only if other 2048-byte block and priority not lower than the oldest write
// - open-row reads and open-row writes are favoured among candidates
// - highest priority among open-row candidates, oldest on a tie
// - read goes before write when the read fifo has room and the write is not of higher priority
// - issue ranks must refresh, read, need refresh, write, may refresh, self-refresh
// - oldest command priority is boosted after a programmable count of transfers
// - interval counter reloads from the refresh interval field and counts down
// - backlog rises on each expiry, falls on each auto-refresh
// - above must level an auto-refresh goes before any access
// - above need level a refresh outranks a write
// - above release level refreshes continue before accesses resume
// - above may level refresh only when idle
// - after each refresh wait the refresh cycle time before re-evaluating
// - gap counter above 7 forces four auto-refreshes
// - refresh counters freeze while in self-refresh
// - a status read completes only after all earlier writes landed; the code waits only for memory writes of its own master
// - one open row per bank, left open until closing is needed
// - self-refresh entry waits for empty queues and zero backlog
`timescale 1ns/1ps
module sdram_command_refresh_scheduler #(
    parameter int masters = 2,
    parameter int cmd_entries = sched_pkg::cmd_depth,
    parameter int wdata_entries = sched_pkg::wdata_depth,
    parameter int rdata_entries = sched_pkg::rdata_depth
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // shared bus port, per master, parallel command and data
    input wire logic [masters-1:0] cmd_valid,
    input wire sched_pkg::cmd_s [masters-1:0] cmd_in,
    output logic [masters-1:0] cmd_ready,
    input wire logic [masters-1:0] wdata_valid,
    input wire logic [masters-1:0][sched_pkg::data_w-1:0] wdata_in,
    output logic [masters-1:0] wdata_ready,
    // read data towards requestors, through the two-entry buffer
    output logic rdata_valid,
    output logic [sched_pkg::data_w-1:0] rdata_out,
    input wire logic rdata_ready,
    // read data coming back from memory
    input wire logic mem_rdata_valid,
    input wire logic [sched_pkg::data_w-1:0] mem_rdata,
    // configuration
    input wire logic [sched_pkg::interval_w-1:0] refresh_interval_field,
    input wire logic [sched_pkg::rfc_w-1:0] refresh_cycle_time,
    input wire logic [sched_pkg::boost_w-1:0] oldest_boost_count,
    input wire logic self_refresh_request,
    input wire logic in_self_refresh,
    input wire logic [sched_pkg::data_w-1:0] status_value,
    // issue towards the command timing engine
    output sched_pkg::issue_s issue,
    output logic issue_valid,
    input wire logic issue_ready,
    output logic [1:0] issue_master
);
    if (masters < 1 || masters > 4 || cmd_entries < 1 || wdata_entries < 1 || rdata_entries < 2)
    begin : g_bad_params
        $error("unsupported scheduler parameters");
    end

    localparam int cw = $clog2(cmd_entries + 1);
    localparam int ww = $clog2(wdata_entries + 1);
    localparam int rw = $clog2(rdata_entries + 1);
    localparam int banks = 1 << sched_pkg::bank_w;

    typedef struct packed {
        logic [masters-1:0][cmd_entries-1:0] q_valid;
        sched_pkg::cmd_s [masters-1:0][cmd_entries-1:0] q_cmd;
        logic [masters-1:0][cmd_entries-1:0][15:0] q_age;
        logic [masters-1:0][wdata_entries-1:0][sched_pkg::data_w-1:0] wq;
        logic [masters-1:0][ww-1:0] wq_count;
        logic [rdata_entries-1:0][sched_pkg::data_w-1:0] rq;
        logic [rw-1:0] rq_count;
        logic [1:0][sched_pkg::data_w-1:0] ob;
        logic [1:0] ob_count;
        logic [15:0] stamp;
        logic [banks-1:0] row_open;
        logic [banks-1:0][sched_pkg::row_w-1:0] open_row;
        logic [sched_pkg::interval_w-1:0] interval;
        logic [sched_pkg::backlog_w-1:0] backlog;
        logic [sched_pkg::backlog_w-1:0] gap;
        logic [sched_pkg::rfc_w-1:0] rfc_wait;
        logic must_burst;
        logic [2:0] forced;
        logic [sched_pkg::boost_w-1:0] transfers;
        logic boost;
        logic [masters-1:0] writes_outstanding;
    } state_s;

    state_s state;
    state_s next_state;

    // per-master candidate: oldest, or a read overtaking an older write
    logic [masters-1:0] cand_valid;
    logic [masters-1:0][$clog2(cmd_entries+1)-1:0] cand_idx;
    int best_r;
    int best_w;
    int old_m;
    int old_i;
    logic [15:0] old_age;

    function automatic logic row_hit(input state_s s, input logic [sched_pkg::addr_w-1:0] a);
        logic [sched_pkg::bank_w-1:0] b;
        b = a[sched_pkg::block_lsb-1 -: sched_pkg::bank_w];
        return s.row_open[b] && s.open_row[b] == a[sched_pkg::row_lsb +: sched_pkg::row_w];
    endfunction : row_hit

    function automatic logic [sched_pkg::prio_w:0] eff_prio(input state_s s, input int m, input int i,
                                                            input int om, input int oi);
        // lower value means higher priority; the boost forces top priority
        if (s.boost && m == om && i == oi)
            return '0;
        return {1'b0, s.q_cmd[m][i].prio};
    endfunction : eff_prio

    always_comb
    begin
        old_m = -1;
        old_i = 0;
        old_age = 16'hffff;
        for (int m = 0; m < masters; m++)
            for (int i = 0; i < cmd_entries; i++)
                if (state.q_valid[m][i] && (old_m < 0 || state.q_age[m][i] < old_age))
                begin
                    old_m = m;
                    old_i = i;
                    old_age = state.q_age[m][i];
                end
        for (int m = 0; m < masters; m++)
        begin
            cand_valid[m] = state.q_valid[m][0];
            cand_idx[m] = '0;
            if (state.q_valid[m][0] && state.q_cmd[m][0].is_write)
                for (int i = cmd_entries - 1; i > 0; i--)
                    if (state.q_valid[m][i] && !state.q_cmd[m][i].is_write && !state.q_cmd[m][i].is_reg
                        && state.q_cmd[m][i].addr[sched_pkg::addr_w-1:sched_pkg::block_lsb]
                           != state.q_cmd[m][0].addr[sched_pkg::addr_w-1:sched_pkg::block_lsb]
                        && state.q_cmd[m][i].prio <= state.q_cmd[m][0].prio)
                        cand_idx[m] = i[$clog2(cmd_entries+1)-1:0];
            // a status read must not pass writes nor leave while writes of its own master are in flight
            if (state.q_valid[m][0] && state.q_cmd[m][0].is_reg && !state.q_cmd[m][0].is_write
                && state.writes_outstanding[m])
                cand_valid[m] = 1'b0;
        end
        best_r = -1;
        best_w = -1;
        for (int m = 0; m < masters; m++)
            if (cand_valid[m])
            begin
                automatic sched_pkg::cmd_s c = state.q_cmd[m][cand_idx[m]];
                automatic logic hit = row_hit(state, c.addr) || c.is_reg;
                automatic int cur = c.is_write ? best_w : best_r;
                automatic logic take = 1'b0;
                if (cur < 0)
                    take = 1'b1;
                else
                begin
                    automatic sched_pkg::cmd_s b = state.q_cmd[cur][cand_idx[cur]];
                    automatic logic bhit = row_hit(state, b.addr) || b.is_reg;
                    automatic logic [sched_pkg::prio_w:0] pc = eff_prio(state, m, cand_idx[m], old_m, old_i);
                    automatic logic [sched_pkg::prio_w:0] pb = eff_prio(state, cur, cand_idx[cur], old_m, old_i);
                    if (hit != bhit)
                        take = hit;
                    else if (pc != pb)
                        take = pc < pb;
                    else
                        take = state.q_age[m][cand_idx[m]] < state.q_age[cur][cand_idx[cur]];
                end
                if (take && c.is_write)
                    best_w = m;
                else if (take)
                    best_r = m;
            end
    end

    logic any_work;
    logic room;
    logic read_ok;
    logic write_ok;
    logic refresh_gate;
    logic ob_push;
    logic [sched_pkg::data_w-1:0] ob_word;

    always_comb
    begin
        next_state = state;
        issue = '{op: sched_pkg::op_none, addr: '0, data: '0};
        issue_valid = 1'b0;
        issue_master = '0;
        any_work = |state.q_valid;
        room = state.rq_count < rw'(rdata_entries);
        read_ok = best_r >= 0 && room
                  && (!state.q_cmd[best_r][cand_idx[best_r]].is_reg || state.ob_count != 2'h2);
        write_ok = best_w >= 0 && state.wq_count[best_w] != '0;
        refresh_gate = state.rfc_wait == '0;
        // a read outranks the write only if the write is not of higher priority
        if (read_ok && write_ok)
            read_ok = !(state.q_cmd[best_w][cand_idx[best_w]].prio
                        < state.q_cmd[best_r][cand_idx[best_r]].prio);
        if ((state.backlog > sched_pkg::level_must || state.must_burst
             || state.forced != '0) && state.backlog != '0)
            issue.op = refresh_gate ? sched_pkg::op_refresh : sched_pkg::op_none;
        else if (read_ok)
            issue.op = sched_pkg::op_read;
        else if (refresh_gate && state.backlog > sched_pkg::level_need)
            issue.op = sched_pkg::op_refresh;
        else if (write_ok)
            issue.op = sched_pkg::op_write;
        else if (refresh_gate && state.backlog > sched_pkg::level_may && !any_work)
            issue.op = sched_pkg::op_refresh;
        else if (self_refresh_request && !any_work && state.backlog == '0 && refresh_gate
                 && !in_self_refresh && state.writes_outstanding == '0)
            issue.op = sched_pkg::op_self_refresh;
        issue_valid = issue.op != sched_pkg::op_none;
        if (issue.op == sched_pkg::op_read)
        begin
            issue_master = 2'(best_r);
            issue.addr = state.q_cmd[best_r][cand_idx[best_r]].addr;
        end
        if (issue.op == sched_pkg::op_write)
        begin
            issue_master = 2'(best_w);
            issue.addr = state.q_cmd[best_w][cand_idx[best_w]].addr;
            issue.data = state.wq[best_w][0];
        end

        // refresh interval and backlog counters, frozen in self-refresh
        if (state.rfc_wait != '0)
            next_state.rfc_wait = state.rfc_wait - 1'b1;
        if (!in_self_refresh)
        begin
            if (state.interval == '0)
            begin
                next_state.interval = refresh_interval_field;
                if (state.backlog != sched_pkg::backlog_max)
                    next_state.backlog = state.backlog + 1'b1;
                if (state.gap != sched_pkg::backlog_max)
                    next_state.gap = state.gap + 1'b1;
            end
            else
                next_state.interval = state.interval - 1'b1;
        end
        if (state.backlog > sched_pkg::level_must)
            next_state.must_burst = 1'b1;
        if (state.gap > sched_pkg::gap_limit && state.forced == '0)
            next_state.forced = sched_pkg::burst_len;

        ob_push = 1'b0;
        ob_word = status_value;
        if (issue_valid && issue_ready)
        begin
            if (issue.op == sched_pkg::op_refresh)
            begin
                next_state.backlog = next_state.backlog - 1'b1;
                next_state.gap = '0;
                next_state.rfc_wait = refresh_cycle_time;
                if (state.forced != '0)
                    next_state.forced = state.forced - 1'b1;
                if (state.backlog - 1'b1 <= sched_pkg::level_release)
                    next_state.must_burst = 1'b0;
            end
            if (issue.op == sched_pkg::op_read || issue.op == sched_pkg::op_write)
            begin
                automatic int m = (issue.op == sched_pkg::op_read) ? best_r : best_w;
                automatic int ix = cand_idx[m];
                automatic sched_pkg::cmd_s c = state.q_cmd[m][ix];
                automatic logic [sched_pkg::bank_w-1:0] b = c.addr[sched_pkg::block_lsb-1 -: sched_pkg::bank_w];
                if (!c.is_reg)
                begin
                    // row stays open until another row of the bank is needed
                    next_state.row_open[b] = 1'b1;
                    next_state.open_row[b] = c.addr[sched_pkg::row_lsb +: sched_pkg::row_w];
                end
                for (int i = 0; i < cmd_entries - 1; i++)
                    if (i >= ix)
                    begin
                        next_state.q_valid[m][i] = state.q_valid[m][i+1];
                        next_state.q_cmd[m][i] = state.q_cmd[m][i+1];
                        next_state.q_age[m][i] = state.q_age[m][i+1];
                    end
                next_state.q_valid[m][cmd_entries-1] = 1'b0;
                if (issue.op == sched_pkg::op_write)
                begin
                    for (int i = 0; i < wdata_entries - 1; i++)
                        next_state.wq[m][i] = state.wq[m][i+1];
                    next_state.wq_count[m] = state.wq_count[m] - 1'b1;
                    next_state.writes_outstanding[m] = !c.is_reg;
                end
                ob_push = issue.op == sched_pkg::op_read && c.is_reg;
                next_state.boost = state.transfers >= oldest_boost_count;
                next_state.transfers = next_state.boost ? '0 : state.transfers + 1'b1;
            end
            if (issue.op == sched_pkg::op_self_refresh)
                next_state.row_open = '0;
        end
        // memory writes land once the engine accepts them, a cycle later
        if (!(issue_valid && issue_ready && issue.op == sched_pkg::op_write))
            next_state.writes_outstanding = '0;

        // read-data fifo from memory, drained into the two-entry output buffer
        if (!ob_push && state.rq_count != '0 && state.ob_count < 2'h2)
        begin
            ob_push = 1'b1;
            ob_word = state.rq[0];
            for (int i = 0; i < rdata_entries - 1; i++)
                next_state.rq[i] = state.rq[i+1];
            next_state.rq_count = state.rq_count - 1'b1;
        end
        if (mem_rdata_valid && next_state.rq_count < rw'(rdata_entries))
        begin
            next_state.rq[next_state.rq_count[rw-1:0]] = mem_rdata;
            next_state.rq_count = next_state.rq_count + 1'b1;
        end
        rdata_valid = state.ob_count != '0;
        rdata_out = state.ob[0];
        if (rdata_valid && rdata_ready)
        begin
            next_state.ob[0] = state.ob[1];
            next_state.ob_count = next_state.ob_count - 1'b1;
        end
        if (ob_push)
        begin
            next_state.ob[next_state.ob_count[0]] = ob_word;
            next_state.ob_count = next_state.ob_count + 1'b1;
        end

        // command and write-data intake, one per master per cycle
        for (int m = 0; m < masters; m++)
        begin
            automatic int n = 0;
            automatic int wn = int'(next_state.wq_count[m]);
            for (int i = 0; i < cmd_entries; i++)
                if (next_state.q_valid[m][i])
                    n++;
            cmd_ready[m] = !state.q_valid[m][cmd_entries-1];
            wdata_ready[m] = state.wq_count[m] < ww'(wdata_entries);
            if (cmd_valid[m] && cmd_ready[m] && n < cmd_entries)
            begin
                next_state.q_valid[m][n] = 1'b1;
                next_state.q_cmd[m][n] = cmd_in[m];
                next_state.q_age[m][n] = state.stamp;
            end
            if (wdata_valid[m] && wdata_ready[m] && wn < wdata_entries)
            begin
                next_state.wq[m][wn] = wdata_in[m];
                next_state.wq_count[m] = next_state.wq_count[m] + 1'b1;
            end
        end
        if (|(cmd_valid & cmd_ready))
            next_state.stamp = state.stamp + 1'b1;
    end

    // age stamps wrap after 65536 command-accepting cycles; ordering is exact only within that span
    always_ff @(posedge clk)
    begin
        state <= reset ? state_s'('0) : next_state;
    end
endmodule : sdram_command_refresh_scheduler

// ==== sched_pkg.sv ====
package sched_pkg;
    localparam int cmd_depth = 7;
    localparam int wdata_depth = 11;
    localparam int rdata_depth = 17;
    localparam int data_w = 64;
    localparam int addr_w = 32;
    localparam int prio_w = 3;
    localparam int block_lsb = 11;
    localparam int bank_w = 3;
    localparam int row_lsb = 13;
    localparam int row_w = 14;
    localparam int interval_w = 13;
    localparam int rfc_w = 8;
    localparam int boost_w = 8;
    localparam int backlog_w = 4;
    localparam logic [backlog_w-1:0] level_may = 4'h0;
    localparam logic [backlog_w-1:0] level_release = 4'h3;
    localparam logic [backlog_w-1:0] level_need = 4'h7;
    localparam logic [backlog_w-1:0] level_must = 4'hb;
    localparam logic [backlog_w-1:0] backlog_max = 4'hf;
    localparam logic [backlog_w-1:0] gap_limit = 4'h7;
    localparam logic [2:0] burst_len = 3'h4;
    localparam logic [addr_w-1:0] status_reg_addr = 32'h0000_0004;

    typedef enum logic [2:0] {op_none, op_read, op_write, op_refresh, op_self_refresh} op_e;

    typedef struct packed {
        logic is_write;
        logic is_reg;
        logic [addr_w-1:0] addr;
        logic [prio_w-1:0] prio;
    } cmd_s;

    typedef struct packed {
        op_e op;
        logic [addr_w-1:0] addr;
        logic [data_w-1:0] data;
    } issue_s;
endpackage : sched_pkg

// ==== sched_monitor.sv ====
`timescale 1ns/1ps
module sched_monitor #(
    parameter int masters = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // queue and read data side
    input wire logic [masters-1:0] cmd_ready,
    input wire logic [masters-1:0] wdata_ready,
    input wire logic rdata_valid,
    input wire logic [sched_pkg::data_w-1:0] rdata_out,
    input wire logic rdata_ready,
    input wire logic mem_rdata_valid,
    // configuration
    input wire logic [sched_pkg::rfc_w-1:0] refresh_cycle_time,
    input wire logic self_refresh_request,
    // issue side
    input wire sched_pkg::issue_s issue,
    input wire logic issue_valid,
    input wire logic issue_ready,
    input wire logic [1:0] issue_master
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_reset_clear; disable iff (1'b0) reset |=> !rdata_valid && cmd_ready == '1; endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("state not cleared by reset");
    property p_ready_after_reset; $fell(reset) |-> wdata_ready == '1 && cmd_ready == '1; endproperty
    a_ready_after_reset: assert property (p_ready_after_reset) else $error("queues not free after reset");
    property p_rdata_hold; rdata_valid && !rdata_ready |=> rdata_valid && $stable(rdata_out); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read word lost while stalled");
    property p_rdata_arrives; mem_rdata_valid |-> ##[2:80] rdata_valid; endproperty
    a_rdata_arrives: assert property (p_rdata_arrives) else $error("memory word never offered");
    property p_refresh_gap;
        issue_valid && issue_ready && issue.op == sched_pkg::op_refresh && refresh_cycle_time > 8'h02
        |=> !(issue_valid && issue.op == sched_pkg::op_refresh) [*2];
    endproperty
    a_refresh_gap: assert property (p_refresh_gap) else $error("refresh inside refresh cycle time");
    property p_sr_requested;
        issue_valid && issue.op == sched_pkg::op_self_refresh |-> self_refresh_request || $past(self_refresh_request);
    endproperty
    a_sr_requested: assert property (p_sr_requested) else $error("self refresh without request");
    property p_status_waits;
        issue_valid && issue_ready && issue.op == sched_pkg::op_write && issue.addr != sched_pkg::status_reg_addr
        |=> !(issue_valid && issue.op == sched_pkg::op_read && issue.addr == sched_pkg::status_reg_addr
              && issue_master == $past(issue_master));
    endproperty
    a_status_waits: assert property (p_status_waits) else $error("status read beside an unlanded write");
    property p_master_range;
        issue_valid && issue.op inside {sched_pkg::op_read, sched_pkg::op_write} |-> issue_master < masters;
    endproperty
    a_master_range: assert property (p_master_range) else $error("access from unknown master");
    c_refresh: cover property (issue_valid && issue_ready && issue.op == sched_pkg::op_refresh);
    c_read: cover property (issue_valid && issue_ready && issue.op == sched_pkg::op_read);
    c_self: cover property (issue_valid && issue_ready && issue.op == sched_pkg::op_self_refresh);
endmodule : sched_monitor
bind sdram_command_refresh_scheduler sched_monitor #(.masters(masters)) mon (.clk, .reset, .cmd_ready, .wdata_ready,
    .rdata_valid, .rdata_out, .rdata_ready, .mem_rdata_valid, .refresh_cycle_time, .self_refresh_request, .issue,
    .issue_valid, .issue_ready, .issue_master);

// ==== engine_model.sv ====
`timescale 1ns/1ps
module engine_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // stall controls
    input wire logic hold,
    input wire logic slow,
    // issue side
    input wire sched_pkg::issue_s issue,
    input wire logic issue_valid,
    output logic issue_ready,
    // read data back
    output logic mem_rdata_valid,
    output logic [sched_pkg::data_w-1:0] mem_rdata
);
    logic ph;
    logic [3:0] v;
    logic [3:0][31:0] a;
    // slow mode accepts on every other cycle only
    assign issue_ready = !hold && (!slow || ph);
    // idle bus shows the inverse so a stale word never looks valid
    assign mem_rdata = v[3] ? {a[3], ~a[3]} : {~a[3], a[3]};
    assign mem_rdata_valid = v[3];
    always_ff @(posedge clk)
    begin
        ph <= reset ? 1'b0 : !ph;
        v <= reset ? 4'h0 : {v[2:0], issue_valid && issue_ready && issue.op == sched_pkg::op_read
            && issue.addr != sched_pkg::status_reg_addr};
        a <= {a[2:0], issue.addr};
    end
endmodule : engine_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] cmd_valid = 2'h0;
    logic [1:0] wdata_valid = 2'h0;
    sched_pkg::cmd_s [1:0] cmd_in = '0;
    logic [1:0][63:0] wdata_in = '0;
    logic [1:0] cmd_ready, wdata_ready, issue_master;
    logic rdata_valid, mem_rdata_valid, issue_valid, issue_ready;
    logic rdata_ready = 1'b0, hold = 1'b0, slow = 1'b0, self_refresh_request = 1'b0, in_self_refresh = 1'b0;
    logic [63:0] rdata_out, mem_rdata;
    logic [12:0] refresh_interval_field = 13'h0100;
    logic [7:0] refresh_cycle_time = 8'h02;
    sched_pkg::issue_s issue;
    sched_pkg::issue_s log_q[$];
    localparam logic [63:0] status_word = 64'h5a5a_0000_0000_a5a5;
    int num_errors = 0, checked = 0, n_ref = 0, cycles = 0;
    sdram_command_refresh_scheduler #(.masters(2)) dut (.clk, .reset, .cmd_valid, .cmd_in, .cmd_ready, .wdata_valid,
        .wdata_in, .wdata_ready, .rdata_valid, .rdata_out, .rdata_ready, .mem_rdata_valid, .mem_rdata,
        .refresh_interval_field, .refresh_cycle_time, .oldest_boost_count(8'h04), .self_refresh_request,
        .in_self_refresh, .status_value(status_word), .issue, .issue_valid, .issue_ready, .issue_master);
    engine_model model (.clk, .reset, .hold, .slow, .issue, .issue_valid, .issue_ready, .mem_rdata_valid, .mem_rdata);
    always #25 clk = ~clk;
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (issue_valid && issue_ready && issue.op == sched_pkg::op_refresh) n_ref <= n_ref + 1;
        else if (issue_valid && issue_ready) log_q.push_back(issue);
        if (cycles == 6000)
        begin
            num_errors++;
            summarize();
        end
    end
    function automatic logic [63:0] mem_word(logic [31:0] a); return {a, ~a}; endfunction : mem_word
    task check(string what, logic [63:0] seen, logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task summarize;
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    task tick(int n); repeat (n) @(posedge clk); #2; endtask : tick
    task wait_log(int n); for (int i = 0; i < 400 && log_q.size() < n; i++) tick(1); endtask : wait_log
    // write data goes ahead of its command so pairing never starves
    task push(int m, logic w, logic r, logic [31:0] a, logic [2:0] p);
        if (w)
        begin
            wdata_in[m] = mem_word(a);
            wdata_valid[m] = 1'b1;
            for (int i = 0; i < 200 && !wdata_ready[m]; i++) tick(1);
            tick(1);
            wdata_valid[m] = 1'b0;
        end
        cmd_in[m] = '{w, r, a, p};
        cmd_valid[m] = 1'b1;
        for (int i = 0; i < 200 && !cmd_ready[m]; i++) tick(1);
        tick(1);
        cmd_valid[m] = 1'b0;
        tick(1);
    endtask : push
    task get_rd(logic [63:0] exp);
        for (int i = 0; i < 300 && !rdata_valid; i++) tick(1);
        check("read data", rdata_out, exp);
        rdata_ready = 1'b1;
        tick(1);
        rdata_ready = 1'b0;
        tick(1);
    endtask : get_rd
    task order_pair(logic [31:0] wa, logic [31:0] ra, sched_pkg::op_e first);
        hold = 1'b1;
        log_q.delete();
        push(0, 1'b1, 1'b0, wa, 3'h2);
        push(0, 1'b0, 1'b0, ra, 3'h2);
        hold = 1'b0;
        wait_log(2);
        check("first of pair", log_q[0].op, first);
        check("write data", log_q[first == sched_pkg::op_read].data, mem_word(wa));
        get_rd(mem_word(ra));
    endtask : order_pair
    task t_order;
        order_pair(32'h0000_1000, 32'h0000_4000, sched_pkg::op_read);
        order_pair(32'h0000_2000, 32'h0000_2100, sched_pkg::op_write);
    endtask : t_order
    task t_fill;
        hold = 1'b1;
        for (int i = 0; i < 7; i++) push(1, 1'b0, 1'b0, 32'h0010_0000 + i * 32'h800, 3'h1);
        check("queue full", cmd_ready[1], 1'b0);
        slow = 1'b1;
        hold = 1'b0;
        for (int i = 0; i < 7; i++) get_rd(mem_word(32'h0010_0000 + i * 32'h800));
        slow = 1'b0;
    endtask : t_fill
    task t_status;
        log_q.delete();
        hold = 1'b1;
        push(0, 1'b1, 1'b0, 32'h0000_3000, 3'h2);
        push(0, 1'b1, 1'b1, sched_pkg::status_reg_addr, 3'h2);
        push(0, 1'b0, 1'b1, sched_pkg::status_reg_addr, 3'h2);
        hold = 1'b0;
        get_rd(status_word);
        check("status read after writes", log_q[2].op, sched_pkg::op_read);
    endtask : t_status
    task t_must;
        int n0;
        refresh_interval_field = 13'h0014;
        refresh_cycle_time = 8'h03;
        hold = 1'b1;
        tick(600);
        push(0, 1'b0, 1'b0, 32'h0000_8000, 3'h0);
        log_q.delete();
        n0 = n_ref;
        hold = 1'b0;
        wait_log(1);
        check("refreshes before access", (n_ref - n0) >= 12, 1'b1);
        get_rd(mem_word(32'h0000_8000));
        refresh_interval_field = 13'h0100;
    endtask : t_must
    task t_self;
        int n0;
        log_q.delete();
        self_refresh_request = 1'b1;
        wait_log(1);
        check("self refresh entry", log_q[0].op, sched_pkg::op_self_refresh);
        self_refresh_request = 1'b0;
        in_self_refresh = 1'b1;
        refresh_interval_field = 13'h0005;
        tick(2);
        n0 = n_ref;
        tick(300);
        check("refresh while asleep", n_ref - n0, 64'h0);
        in_self_refresh = 1'b0;
    endtask : t_self
    initial
    begin
        tick(6);
        reset = 1'b0;
        tick(1);
        check("cmd ready after reset", cmd_ready, 2'h3);
        t_order();
        t_fill();
        t_status();
        t_must();
        t_self();
        summarize();
    end
endmodule : tb_top
